/* inc/sbio_pkg.sv */
// shared types and constants of the serial bit i/o unit
package sbio_pkg;
  localparam logic [3:0] BASE_REG_IDX = 4'hc;
  localparam int         ADDR_LSB     = 1;
  localparam int         ADDR_MSB     = 12;
  localparam int         ADDR_W       = 12;
  localparam int         DISP_W       = 8;
  localparam int         CNT_W        = 4;
  localparam int         EQ_BIT       = 2;
  localparam logic [4:0] FULL_CNT     = 5'h10;
  localparam logic [4:0] BYTE_MAX     = 5'h08;
  localparam int         HI_BYTE_LSB  = 8;
  localparam int         SETTLE_NS    = 12;
  localparam int         CLK_NS       = 4;
  localparam logic [1:0] SETTLE_CYC   = 2'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    OP_SET_ONE  = 3'h0,
    OP_SET_ZERO = 3'h1,
    OP_TEST     = 3'h2,
    OP_LOAD     = 3'h3,
    OP_STORE    = 3'h4
  } sbio_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_ACT   = 2'h3,
    ST_DONE  = 2'h2
  } sbio_fsm_t;

  typedef struct packed {
    sbio_op_t          op;
    logic [15:0]       base;
    logic [DISP_W-1:0] disp;
    logic [CNT_W-1:0]  cnt;
    logic [15:0]       word;
  } sbio_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              out_line;
    logic              strobe;
  } sbio_pins_t;

  typedef struct packed {
    logic        done;
    logic        eq;
    logic [15:0] store_word;
    logic        store_we;
  } sbio_res_t;

  typedef struct packed {
    sbio_fsm_t   fsm;
    sbio_op_t    op;
    sbio_pins_t  pins;
    sbio_res_t   res;
    logic [15:0] shreg;
    logic [15:0] acc;
    logic [7:0]  keep;
    logic        wide;
    logic [4:0]  left;
    logic [3:0]  idx;
    logic [1:0]  settle;
    logic        busy;
    logic [3:0]  base_sel;
    logic        sync1;
    logic        sync2;
  } sbio_state_t;
endpackage

/* logic/sbio_unit.sv */
// serial bit i/o unit: bit set, clear, test and field shifts
// Behaviour
// - base address comes from workspace register 12
// - only base bits 1..12 form bit address
// - bit address drives the address lines
// - single-bit ops add signed 8-bit displacement
// - set/zero ops drive output bit, one transfer
// - test copies input bit into equal flag
// - count 1..15 moves that many, 0 moves 16
// - fields start at base, no displacement
// - load field shifts memory bits onto output
// - store field samples input bits into memory
// - short fields use high byte, lsb first
// - wide fields use whole word from bit 0
// - unused destination bits written as zero
// - short store leaves other byte unchanged
// - three dedicated lines, no parallel data bus
// - 4096 input and 4096 output bits
// - address on twelve lines plus three lines
`timescale 1ns/10ps
`default_nettype none
module sbio_unit
  import sbio_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic        i_start,
  input  wire sbio_req_t   i_req,
  input  wire logic        i_serial_io_input_line,
  output logic             o_busy,
  output logic [3:0]       o_base_reg_sel,
  output sbio_pins_t       o_pins,
  output sbio_res_t        o_res
);

  sbio_state_t s;
  sbio_state_t next_s;
  logic [ADDR_W-1:0] hw_base;
  logic [ADDR_W-1:0] disp_ext;
  logic              single;
  logic [4:0]        nbits;
  logic              wide;

  // software base is twice the hardware base
  assign hw_base  = i_req.base[ADDR_MSB:ADDR_LSB];
  assign disp_ext = {{(ADDR_W-DISP_W){i_req.disp[DISP_W-1]}}, i_req.disp};
  assign single   = i_req.op inside {OP_SET_ONE, OP_SET_ZERO, OP_TEST};
  // count 0 means a full word
  assign nbits    = (i_req.cnt == 4'h0) ? FULL_CNT : {1'b0, i_req.cnt};
  assign wide     = nbits > BYTE_MAX;

  always_comb begin
    next_s              = s;
    next_s.pins.strobe  = 1'b0;
    next_s.res.done     = 1'b0;
    next_s.res.store_we = 1'b0;
    // only the second flop is ever read
    next_s.sync1        = i_serial_io_input_line;
    next_s.sync2        = s.sync1;
    case (s.fsm)
      ST_IDLE: begin
        if (i_start) begin
          next_s.busy   = 1'b1;
          next_s.op     = i_req.op;
          next_s.fsm    = ST_SETUP;
          next_s.settle = SETTLE_CYC - 2'h1;
          next_s.acc    = 16'h0000;
          next_s.idx    = 4'h0;
          next_s.keep   = i_req.word[7:0];
          if (single) begin
            next_s.pins.addr     = hw_base + disp_ext;
            next_s.left          = 5'h01;
            next_s.wide          = 1'b0;
            next_s.pins.out_line = (i_req.op == OP_SET_ONE);
          end else begin
            next_s.pins.addr = hw_base;
            next_s.left      = nbits;
            next_s.wide      = wide;
            // short fields live in the high byte
            next_s.shreg = wide ? i_req.word
                         : {8'h00, i_req.word[15:HI_BYTE_LSB]};
            if (i_req.op == OP_LOAD) begin
              next_s.pins.out_line = wide ? i_req.word[0]
                                   : i_req.word[HI_BYTE_LSB];
            end
          end
        end
      end
      ST_SETUP: begin
        // lets the address settle and input sync catch up
        if (s.settle == 2'h0) begin
          next_s.fsm = ST_ACT;
          // strobe rides the active cycle, address and data already standing
          next_s.pins.strobe = (s.op inside {OP_SET_ONE, OP_SET_ZERO, OP_LOAD});
        end else begin
          next_s.settle = s.settle - 2'h1;
        end
      end
      ST_ACT: begin
        case (s.op)
          OP_TEST: begin
            next_s.res.eq = s.sync2;
          end
          OP_STORE: begin
            next_s.acc[s.idx] = s.sync2;
          end
          default: begin
            next_s.pins.strobe = 1'b0;
          end
        endcase
        next_s.left = s.left - 5'h01;
        if (s.left == 5'h01) begin
          next_s.fsm = ST_DONE;
        end else begin
          next_s.fsm       = ST_SETUP;
          next_s.settle    = SETTLE_CYC - 2'h1;
          next_s.idx       = s.idx + 4'h1;
          next_s.pins.addr = s.pins.addr + 12'h001;
          next_s.shreg     = {1'b0, s.shreg[15:1]};
          if (s.op == OP_LOAD) begin
            next_s.pins.out_line = s.shreg[1];
          end
        end
      end
      ST_DONE: begin
        next_s.fsm      = ST_IDLE;
        next_s.busy     = 1'b0;
        next_s.res.done = 1'b1;
        if (s.op == OP_STORE) begin
          next_s.res.store_we   = 1'b1;
          // short store keeps the low byte as it was
          next_s.res.store_word = s.wide ? s.acc
                                : {s.acc[7:0], s.keep};
        end
      end
      default: begin
        next_s     = s;
        next_s.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s          <= '0;
      s.base_sel <= BASE_REG_IDX;
    end else begin
      s <= next_s;
    end
  end

  // outputs come straight from the state flops
  assign o_busy         = s.busy;
  assign o_base_reg_sel = s.base_sel;
  assign o_pins         = s.pins;
  assign o_res          = s.res;

  // helper: strobes and cycles seen in the running transfer
  logic [4:0] strb_cnt;
  logic [4:0] exp_cnt;
  logic [6:0] cyc_cnt;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      strb_cnt <= 5'h00;
      exp_cnt  <= 5'h00;
      cyc_cnt  <= 7'h00;
    end else if (s.fsm == ST_IDLE && i_start) begin
      strb_cnt <= 5'h00;
      exp_cnt  <= single ? 5'h01 : nbits;
      cyc_cnt  <= 7'h01;
    end else begin
      if (s.pins.strobe) begin
        strb_cnt <= strb_cnt + 5'h01;
      end
      if (s.busy) begin
        cyc_cnt <= cyc_cnt + 7'h01;
      end
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  AST_STROBE_PULSE: assert property (
    s.pins.strobe |=> !s.pins.strobe)
    else $error("strobe held longer than one cycle");

  AST_ADDR_STEP: assert property (
    (s.fsm == ST_ACT && s.left > 5'h01)
      |=> s.pins.addr == $past(s.pins.addr) + 12'h001)
    else $error("bit address did not step by one");

  AST_FIELD_BASE: assert property (
    (s.fsm == ST_IDLE && i_start && !single)
      |=> s.pins.addr == $past(i_req.base[12:1]))
    else $error("field did not start at base");

  AST_SINGLE_DISP: assert property (
    (s.fsm == ST_IDLE && i_start && single)
      |=> s.pins.addr == $past(hw_base + disp_ext))
    else $error("displacement not applied");

  AST_SET_LEVEL: assert property (
    (s.pins.strobe && s.op inside {OP_SET_ONE, OP_SET_ZERO})
      |-> s.pins.out_line == (s.op == OP_SET_ONE))
    else $error("set or zero drove wrong level");

  AST_TEST_EQ: assert property (
    (s.fsm == ST_ACT && s.op == OP_TEST)
      |=> ##1 (s.res.done && s.res.eq == $past(s.sync2, 2)))
    else $error("equal flag not the sampled bit");

  AST_STROBE_COUNT: assert property (
    (s.res.done && s.op inside {OP_LOAD, OP_SET_ONE, OP_SET_ZERO})
      |-> strb_cnt == exp_cnt)
    else $error("wrong number of strobes");

  AST_NO_IN_STROBE: assert property (
    (s.busy && s.op inside {OP_TEST, OP_STORE}) |-> !s.pins.strobe)
    else $error("strobe during an input operation");

  AST_BYTE_KEEP: assert property (
    (s.res.store_we && !s.wide)
      |-> s.res.store_word[7:0] == s.keep)
    else $error("short store touched the other byte");

  AST_CYCLE_COUNT: assert property (
    s.res.done |-> cyc_cnt == {exp_cnt, 2'b00} + 7'h02)
    else $error("instruction took the wrong number of cycles");

  AST_DONE_PULSE: assert property (
    s.res.done |=> !s.res.done)
    else $error("done held longer than one cycle");

  AST_DONE_IDLE: assert property (
    s.res.done |-> !s.busy)
    else $error("still busy at done");

  AST_STROBE_IN_ACT: assert property (
    s.pins.strobe |-> s.fsm == ST_ACT)
    else $error("strobe outside the active cycle");

  AST_IDLE_QUIET: assert property (
    s.fsm == ST_IDLE |-> !s.pins.strobe)
    else $error("strobe while idle");

  AST_OUT_STROBE: assert property (
    (s.fsm == ST_ACT && s.op inside {OP_SET_ONE, OP_SET_ZERO, OP_LOAD}) |-> s.pins.strobe)
    else $error("output bit not strobed");

  AST_ADDR_HOLD: assert property (
    s.fsm == ST_SETUP |=> $stable(s.pins.addr))
    else $error("bit address moved while settling");

  AST_OUT_HOLD: assert property (
    s.fsm == ST_SETUP |=> $stable(s.pins.out_line))
    else $error("output line moved while settling");

  AST_SETTLE_LEN: assert property (
    (s.fsm == ST_IDLE && i_start)
      |=> s.fsm == ST_SETUP ##1 s.fsm == ST_SETUP ##1 s.fsm == ST_SETUP ##1 s.fsm == ST_ACT)
    else $error("settle time per bit is not three cycles");

  AST_SINGLE_BITS: assert property (
    (s.fsm == ST_IDLE && i_start && single)
      |=> s.left == 5'h01)
    else $error("single-bit op not one transfer");

  AST_WIDE_SEL: assert property (
    (s.fsm == ST_IDLE && i_start && !single)
      |=> s.wide == ($past(i_req.cnt) == 4'h0 || $past(i_req.cnt) > 4'h8))
    else $error("field width class wrong");

  AST_LOAD_FIRST: assert property (
    (s.fsm == ST_IDLE && i_start && i_req.op == OP_LOAD)
      |=> s.pins.out_line == (s.wide ? $past(i_req.word[0]) : $past(i_req.word[HI_BYTE_LSB])))
    else $error("first field bit taken from wrong place");

  AST_STORE_ZERO: assert property (
    s.res.store_we
      |-> ((s.wide ? s.res.store_word : {8'h00, s.res.store_word[15:8]}) >> exp_cnt) == 16'h0000)
    else $error("bits beyond the count not zero");

  AST_WE_WITH_DONE: assert property (
    s.res.store_we |-> (s.res.done && s.op == OP_STORE))
    else $error("store write outside a store");

  AST_IN_NO_STROBE_CNT: assert property (
    (s.res.done && s.op inside {OP_TEST, OP_STORE}) |-> strb_cnt == 5'h00)
    else $error("input operation gave strobes");

  AST_IN_OUT_HOLD: assert property (
    (s.busy && s.op inside {OP_TEST, OP_STORE}) |=> $stable(s.pins.out_line))
    else $error("output line moved during an input operation");

  AST_EQ_HOLD: assert property (
    !(s.fsm == ST_ACT && s.op == OP_TEST) |=> $stable(s.res.eq))
    else $error("equal flag changed outside a test");

  COV_LOAD_FULL: cover property (
    s.res.done && s.op == OP_LOAD && exp_cnt == FULL_CNT);
  COV_STORE_BYTE: cover property (s.res.store_we && !s.wide);
  COV_TEST_ONE: cover property (s.res.done && s.op == OP_TEST && s.res.eq);
  COV_SET_ZERO: cover property (s.res.done && s.op == OP_SET_ZERO);
  COV_STORE_WIDE: cover property (s.res.store_we && s.wide);

endmodule
`default_nettype wire

/* testbench/sbio_periph.sv */
// peripheral model on the serial bit bus
`timescale 1ns/10ps
`default_nettype none
module sbio_periph
  import sbio_pkg::*;
(
  input  wire logic          i_core_clk,
  input  wire sbio_pins_t    i_pins,
  input  wire logic [4095:0] i_in_bits,
  output logic               o_in_line,
  output logic [4095:0]      o_out_bits
);
  // output bits hold unknown until first strobe, as real latches do
  always_ff @(posedge i_core_clk) begin
    if (i_pins.strobe) begin
      o_out_bits[i_pins.addr] <= i_pins.out_line;
    end
  end
  assign o_in_line = i_in_bits[i_pins.addr];
endmodule
`default_nettype wire

/* testbench/serial_bit_io_unit_test.sv */
// self-checking bench of the serial bit i/o unit
`timescale 1ns/10ps
`default_nettype none
module serial_bit_io_unit_test;
  import sbio_pkg::*;
  logic          clk;
  logic          srst;
  logic          start;
  sbio_req_t     req;
  logic          in_line;
  logic          busy;
  logic [3:0]    sel;
  sbio_pins_t    pins;
  sbio_res_t     res;
  logic [4095:0] in_bits;
  logic [4095:0] out_bits;
  int            fails;
  int            n_compared;
  int            seed;
  sbio_unit DUT (.i_core_clk(clk), .i_srst(srst), .i_start(start), .i_req(req), .i_serial_io_input_line(in_line),
    .o_busy(busy), .o_base_reg_sel(sel), .o_pins(pins), .o_res(res));
  sbio_periph PERIPH (.i_core_clk(clk), .i_pins(pins), .i_in_bits(in_bits), .o_in_line(in_line),
    .o_out_bits(out_bits));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic int nbits(input logic [3:0] c);
    nbits = (c == 4'h0) ? 16 : int'(c);
  endfunction
  // field ops ignore the displacement
  function automatic logic [11:0] bit_addr(input sbio_req_t r);
    bit_addr = r.base[12:1] + ((r.op > OP_TEST) ? 12'h000 : {{4{r.disp[7]}}, r.disp});
  endfunction
  function automatic logic [15:0] exp_store(input sbio_req_t r);
    logic [15:0] f;
    f = '0;
    for (int i = 0; i < nbits(r.cnt); i++) f[i] = in_bits[r.base[12:1] + 12'(i)];
    exp_store = (nbits(r.cnt) > 8) ? f : {f[7:0], r.word[7:0]};
  endfunction
  task automatic run(input sbio_op_t op, input logic [15:0] base, input logic [7:0] disp,
    input logic [3:0] cnt, input logic [15:0] word);
    sbio_req_t   r;
    int          k;
    logic [11:0] a;
    r = '{op: op, base: base, disp: disp, cnt: cnt, word: word};
    a = bit_addr(r);
    start <= 1'b1;
    req <= r;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (res.done !== 1'b1 && k < 100);
    if (k >= 100) begin
      fails++;
      $display("wrong value done: expected 1, seen timeout");
      end_sim();
    end
    case (op)
      OP_SET_ONE: check("set bit", 16'(out_bits[a]), 16'h0001);
      OP_SET_ZERO: check("cleared bit", 16'(out_bits[a]), 16'h0000);
      OP_TEST: check("equal flag", 16'(res.eq), 16'(in_bits[a]));
      OP_LOAD: begin
        for (int i = 0; i < nbits(cnt); i++)
          check("loaded bit", 16'(out_bits[a + 12'(i)]), 16'(nbits(cnt) > 8 ? word[i] : word[8 + i]));
      end
      OP_STORE: begin
        check("stored word", res.store_word, exp_store(r));
        check("store write", 16'(res.store_we), 16'h0001);
      end
      default: ;
    endcase
    // one spare edge so the next start never meets the done cycle
    @(posedge clk);
  endtask
  initial begin
    logic [3:0] cnts [4];
    cnts = '{4'h0, 4'h1, 4'h8, 4'h9};
    seed = 16911;
    fails = 0;
    n_compared = 0;
    srst = 1'b1;
    start = 1'b0;
    req = '0;
    for (int i = 0; i < 4096; i += 32) in_bits[i +: 32] = $random(seed);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("base register select", 16'(sel), 16'(BASE_REG_IDX));
    check("busy after reset", 16'(busy), 16'h0000);
    @(posedge clk);
    // step back 128 from bit 4095, then clear the same bit
    run(OP_SET_ONE, 16'hffff, 8'h80, 4'h0, 16'h0000);
    run(OP_SET_ZERO, 16'hffff, 8'h80, 4'h0, 16'h0000);
    run(OP_TEST, 16'h8000, 8'h7f, 4'h0, 16'h0000);
    foreach (cnts[j]) begin
      run(OP_LOAD, 16'hfffe, 8'h55, cnts[j], 16'($random(seed)));
      run(OP_STORE, 16'h0ff0, 8'h55, cnts[j], 16'($random(seed)));
    end
    for (int n = 0; n < 40; n++)
      run(sbio_op_t'(3'($unsigned($random(seed)) % 5)), 16'($random(seed)), 8'($random(seed)),
        4'($random(seed)), 16'($random(seed)));
    end_sim();
  end
endmodule
`default_nettype wire
